/* File: inc/rcr_map.vh */
// Purpose: Constants of the reset cause recorder: offsets, field positions, reset values.
// Assumes: Included by rtl/rcr_top.v only.
// Notes: Offsets are byte addresses on a 32-bit AHB-Lite bus.
// What this block does
// R1 - Every reset or wake-up updates flag bits in the core status and power-control registers.
// R2 - Every reset other than a wake-up from sleep reloads the program counter with zero.
// R3 - Power-on clears both stack flags and the power-on flag and sets the others.
// R4 - Brown-out clears both stack flags and brownout, sets ext, instr, expiry and sleep flags.
// R5 - A watchdog reset clears the watchdog reset and expiry flags only.
// R6 - Watchdog expiry in sleep clears expiry and sleep flags and resumes at the next instruction.
// R7 - Interrupt wake-up sets the expiry flag, clears the sleep flag and resumes.
// R8 - With global interrupts on, an interrupt wake-up runs one instruction, pushes and jumps to 0004h.
// R9 - External reset pin in normal run clears only the external-reset flag.
// R10 - External reset pin in sleep clears ext flag, sets expiry flag, clears sleep flag.
// R11 - The reset instruction clears the reset-instruction flag and restarts from zero.
// R12 - With stack fault reset enabled, an overflow sets the stack overflow flag and resets.
// R13 - With stack fault reset enabled, an underflow sets the stack underflow flag and resets.
// R14 - Flags that an event does not name keep their values across it.
// R15 - Software writes the active-low flags back to one after reading them.
`ifndef RCR_MAP_VH
`define RCR_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RCR_OFS_PWR_CTL 8'h00
`define RCR_OFS_CORE_STAT 8'h04
`define RCR_OFS_EVT_STAT 8'h08
`define RCR_OFS_EVT_MASK 8'h0c
`define RCR_OFS_CTRL 8'h10

// ----------------------------------------
// Power-control register fields
// ----------------------------------------
`define RCR_PC_BROWNOUT 0
`define RCR_PC_POWER_ON 1
`define RCR_PC_RESET_INSTR 2
`define RCR_PC_EXT_RESET 3
`define RCR_PC_WATCHDOG 4
`define RCR_PC_STACK_UNF 6
`define RCR_PC_STACK_OVF 7
`define RCR_PC_WR_MASK 8'hdf
`define RCR_PC_RESET 8'h1d

// ----------------------------------------
// Core status fields and others
// ----------------------------------------
`define RCR_CS_SLEEP 0
`define RCR_CS_EXPIRY 1
`define RCR_CS_RESET 2'h3
`define RCR_CTRL_STK_EN 0
`define RCR_CTRL_RESET 1'h1
`define RCR_EV_BROWNOUT 0
`define RCR_EV_EXT_RESET 1
`define RCR_EV_WDOG_RESET 2
`define RCR_EV_WDOG_WAKE 3
`define RCR_EV_IRQ_WAKE 4
`define RCR_EV_RESET_INSTR 5
`define RCR_EV_STACK_OVF 6
`define RCR_EV_STACK_UNF 7
`define RCR_RESET_VECTOR 15'h0000
`define RCR_IRQ_VECTOR 15'h0004

`endif

/* File: rtl/rcr_top.v */
// Purpose: Records reset and wake-up causes and steers the program counter.
// Assumes: Core event inputs are one-cycle pulses on REF_CLK; pin and brownout are async.
// Notes: One event is honoured per cycle, in fixed priority; registers on AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "rcr_map.vh"

module rcr_top #(
  parameter PC_W = 15
) (
  input wire REF_CLK,
  input wire RSTN,
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire EXTERNAL_RESET_PIN,
  input wire BROWNOUT_DET,
  input wire WATCHDOG_TIMER_EXPIRE,
  input wire SLEEP_ENTER,
  input wire IRQ_WAKE,
  input wire RESET_INSTR,
  input wire STACK_OVERFLOW,
  input wire STACK_UNDERFLOW,
  input wire GLOBAL_IRQ_EN,
  input wire INSTR_DONE,
  output reg [7:0] POWER_CONTROL_REG,
  output reg [1:0] CORE_STATUS,
  output reg SLEEPING,
  output reg PC_LOAD,
  output reg [PC_W-1:0] PC_LOAD_ADDR,
  output reg RESUME_NEXT,
  output reg PUSH_RETURN,
  output reg IRQ
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Stage one is read only by stage two; edge detect looks at stage two and three.
  reg [1:0] meta_ff;
  reg [1:0] sync_ff;
  reg [1:0] prev_ff;
  wire ext_rise;
  wire bdet_rise;

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      meta_ff <= 2'h0;
      sync_ff <= 2'h0;
      prev_ff <= 2'h0;
    end
    else
    begin
      meta_ff <= {BROWNOUT_DET, EXTERNAL_RESET_PIN};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign ext_rise = sync_ff[0] & ~prev_ff[0];
  assign bdet_rise = sync_ff[1] & ~prev_ff[1];

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  reg ctrl_ff;
  reg [7:0] evt_stat_ff;
  reg [7:0] evt_mask_ff;
  reg [31:0] nxt_hrdata;
  wire addr_phase;
  wire wr_pwr;
  wire wr_stat;
  wire wr_mask;
  wire wr_ctrl;

  assign addr_phase = HSEL & HTRANS[1] & HREADY;
  assign wr_pwr = wr_pend_ff & (wr_addr_ff == `RCR_OFS_PWR_CTL);
  assign wr_stat = wr_pend_ff & (wr_addr_ff == `RCR_OFS_EVT_STAT);
  assign wr_mask = wr_pend_ff & (wr_addr_ff == `RCR_OFS_EVT_MASK);
  assign wr_ctrl = wr_pend_ff & (wr_addr_ff == `RCR_OFS_CTRL);

  // Read data is latched at the address phase, so reads have no wait state
  always @*
  begin
    nxt_hrdata = 32'h0000_0000;
    if (addr_phase && !HWRITE)
    begin
      case (HADDR)
        `RCR_OFS_PWR_CTL: nxt_hrdata = {24'h00_0000, POWER_CONTROL_REG};
        `RCR_OFS_CORE_STAT: nxt_hrdata = {30'h0000_0000, CORE_STATUS};
        `RCR_OFS_EVT_STAT: nxt_hrdata = {24'h00_0000, evt_stat_ff};
        `RCR_OFS_EVT_MASK: nxt_hrdata = {24'h00_0000, evt_mask_ff};
        `RCR_OFS_CTRL: nxt_hrdata = {31'h0000_0000, ctrl_ff};
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      ctrl_ff <= `RCR_CTRL_RESET;
      evt_mask_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= addr_phase & HWRITE;
      wr_addr_ff <= HADDR;
      HRDATA <= nxt_hrdata;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (wr_ctrl)
        ctrl_ff <= HWDATA[`RCR_CTRL_STK_EN];
      if (wr_mask)
        evt_mask_ff <= HWDATA[7:0];
    end
  end

  // ----------------------------------------
  // Event selection
  // ----------------------------------------
  // Fixed priority: brownout, pin, watchdog, stack faults, reset instruction, irq wake.
  localparam [6:0] EV_NONE = 7'h00;
  localparam [6:0] EV_BROWN = 7'h01;
  localparam [6:0] EV_EXT = 7'h02;
  localparam [6:0] EV_WDOG = 7'h04;
  localparam [6:0] EV_OVF = 7'h08;
  localparam [6:0] EV_UNF = 7'h10;
  localparam [6:0] EV_RINSTR = 7'h20;
  localparam [6:0] EV_IRQ = 7'h40;
  reg [6:0] ev;
  reg stk_en;

  always @*
  begin
    stk_en = ctrl_ff;
    if (bdet_rise)
      ev = EV_BROWN;
    else if (ext_rise)
      ev = EV_EXT;
    else if (WATCHDOG_TIMER_EXPIRE)
      ev = EV_WDOG;
    else if (STACK_OVERFLOW && stk_en)
      ev = EV_OVF;
    else if (STACK_UNDERFLOW && stk_en)
      ev = EV_UNF;
    else if (RESET_INSTR)
      ev = EV_RINSTR;
    else if (IRQ_WAKE && SLEEPING)
      ev = EV_IRQ;
    else
      ev = EV_NONE;
  end

  // ----------------------------------------
  // Cause flags and program counter steering
  // ----------------------------------------
  reg [7:0] nxt_pwr;
  reg [1:0] nxt_core;
  reg nxt_sleep;
  reg nxt_pc_load;
  reg [PC_W-1:0] nxt_pc_addr;
  reg nxt_resume;
  reg nxt_push;
  reg irq_pend_ff;
  reg nxt_irq_pend;
  reg [7:0] ev_hit;

  always @*
  begin
    // Software write first, so a same-cycle hardware event overrides it [R14]
    nxt_pwr = wr_pwr ? (HWDATA[7:0] & `RCR_PC_WR_MASK) : POWER_CONTROL_REG;
    nxt_core = CORE_STATUS;
    nxt_sleep = SLEEPING;
    nxt_pc_load = 1'b0;
    nxt_pc_addr = PC_LOAD_ADDR;
    nxt_resume = 1'b0;
    nxt_push = 1'b0;
    nxt_irq_pend = irq_pend_ff;
    ev_hit = 8'h00;
    if (SLEEP_ENTER && !SLEEPING)
    begin
      nxt_sleep = 1'b1;
      nxt_core[`RCR_CS_SLEEP] = 1'b0;
      nxt_core[`RCR_CS_EXPIRY] = 1'b1;
    end
    case (ev)
      EV_NONE:
      begin
        if (irq_pend_ff && INSTR_DONE)
        begin
          nxt_irq_pend = 1'b0;
          nxt_push = 1'b1; // [R8]
          nxt_pc_load = 1'b1; // [R8]
          nxt_pc_addr = `RCR_IRQ_VECTOR; // [R8]
        end
      end
      EV_BROWN:
      begin
        nxt_pwr[`RCR_PC_STACK_OVF] = 1'b0; // [R4]
        nxt_pwr[`RCR_PC_STACK_UNF] = 1'b0; // [R4]
        nxt_pwr[`RCR_PC_BROWNOUT] = 1'b0; // [R4]
        nxt_pwr[`RCR_PC_EXT_RESET] = 1'b1; // [R4]
        nxt_pwr[`RCR_PC_RESET_INSTR] = 1'b1; // [R4]
        nxt_core = 2'h3; // [R4]
        ev_hit[`RCR_EV_BROWNOUT] = 1'b1;
      end
      EV_EXT:
      begin
        nxt_pwr[`RCR_PC_EXT_RESET] = 1'b0; // [R9] [R10]
        if (SLEEPING)
        begin
          nxt_core[`RCR_CS_EXPIRY] = 1'b1; // [R10]
          nxt_core[`RCR_CS_SLEEP] = 1'b0; // [R10]
        end
        ev_hit[`RCR_EV_EXT_RESET] = 1'b1;
      end
      EV_WDOG:
      begin
        nxt_core[`RCR_CS_EXPIRY] = 1'b0; // [R5] [R6]
        if (SLEEPING)
        begin
          nxt_core[`RCR_CS_SLEEP] = 1'b0; // [R6]
          ev_hit[`RCR_EV_WDOG_WAKE] = 1'b1;
        end
        else
        begin
          nxt_pwr[`RCR_PC_WATCHDOG] = 1'b0; // [R5]
          ev_hit[`RCR_EV_WDOG_RESET] = 1'b1;
        end
      end
      EV_OVF:
      begin
        nxt_pwr[`RCR_PC_STACK_OVF] = 1'b1; // [R12]
        ev_hit[`RCR_EV_STACK_OVF] = 1'b1;
      end
      EV_UNF:
      begin
        nxt_pwr[`RCR_PC_STACK_UNF] = 1'b1; // [R13]
        ev_hit[`RCR_EV_STACK_UNF] = 1'b1;
      end
      EV_RINSTR:
      begin
        nxt_pwr[`RCR_PC_RESET_INSTR] = 1'b0; // [R11]
        ev_hit[`RCR_EV_RESET_INSTR] = 1'b1;
      end
      EV_IRQ:
      begin
        nxt_core[`RCR_CS_EXPIRY] = 1'b1; // [R7]
        nxt_core[`RCR_CS_SLEEP] = 1'b0; // [R7]
        nxt_resume = 1'b1; // [R7]
        nxt_irq_pend = GLOBAL_IRQ_EN; // [R8]
        ev_hit[`RCR_EV_IRQ_WAKE] = 1'b1;
      end
      default:
      begin
        nxt_irq_pend = 1'b0;
      end
    endcase
    // Any event other than the two wake-ups is a reset: restart from zero [R2]
    if (ev != EV_NONE && ev != EV_IRQ && !(ev == EV_WDOG && SLEEPING))
    begin
      nxt_pc_load = 1'b1; // [R2]
      nxt_pc_addr = `RCR_RESET_VECTOR; // [R2] [R11]
      nxt_irq_pend = 1'b0;
      nxt_sleep = 1'b0;
    end
    if (ev == EV_WDOG && SLEEPING)
    begin
      nxt_resume = 1'b1; // [R6]
      nxt_sleep = 1'b0;
    end
    if (ev == EV_IRQ)
      nxt_sleep = 1'b0;
  end

  // Async reset is the power-on event; its constants are the power-on flag values
  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      POWER_CONTROL_REG <= `RCR_PC_RESET; // [R3]
      CORE_STATUS <= `RCR_CS_RESET; // [R3]
      SLEEPING <= 1'b0;
      PC_LOAD <= 1'b1; // [R2]
      PC_LOAD_ADDR <= `RCR_RESET_VECTOR;
      RESUME_NEXT <= 1'b0;
      PUSH_RETURN <= 1'b0;
      irq_pend_ff <= 1'b0;
    end
    else
    begin
      POWER_CONTROL_REG <= nxt_pwr;
      CORE_STATUS <= nxt_core;
      SLEEPING <= nxt_sleep;
      PC_LOAD <= nxt_pc_load;
      PC_LOAD_ADDR <= nxt_pc_addr;
      RESUME_NEXT <= nxt_resume;
      PUSH_RETURN <= nxt_push;
      irq_pend_ff <= nxt_irq_pend;
    end
  end

  // ----------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------
  // Set wins over write-one-to-clear so no event is lost
  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      evt_stat_ff <= 8'h00;
      IRQ <= 1'b0;
    end
    else
    begin
      evt_stat_ff <= (evt_stat_ff & ~(wr_stat ? HWDATA[7:0] : 8'h00)) | ev_hit;
      IRQ <= |(((evt_stat_ff & ~(wr_stat ? HWDATA[7:0] : 8'h00)) | ev_hit) & evt_mask_ff);
    end
  end

endmodule
`default_nettype wire

/* File: sim/rcr_core_model.sv */
// Purpose: Core stand-in that finishes one instruction after a wake-up.
// Assumes: RESUME_NEXT is a one-cycle pulse.
// Notes: The delay input makes the core answer promptly or slowly.
`timescale 1ns/10ps
`default_nettype none
module rcr_core_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic resume,
  input wire logic [3:0] dly,
  output logic done
);
  logic [4:0] cnt_ff;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff <= 5'h0;
      done <= 1'b0;
    end
    else
    begin
      done <= cnt_ff == 5'h1;
      if (resume)
      begin
        cnt_ff <= {1'b0, dly} + 5'h1;
      end
      else if (cnt_ff != 5'h0)
      begin
        cnt_ff <= cnt_ff - 5'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/rcr_top_asserts.sv */
// Purpose: Port timing checks of the cause recorder.
// Assumes: Core pulses are judged only while both pins rest low.
// Notes: Pin events use a window, as the sync depth is internal.
`timescale 1ns/10ps
`default_nettype none
module rcr_top_asserts #(
  parameter PC_W = 15
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic EXTERNAL_RESET_PIN,
  input wire logic BROWNOUT_DET,
  input wire logic WATCHDOG_TIMER_EXPIRE,
  input wire logic IRQ_WAKE,
  input wire logic RESET_INSTR,
  input wire logic STACK_OVERFLOW,
  input wire logic STACK_UNDERFLOW,
  input wire logic INSTR_DONE,
  input wire logic [7:0] POWER_CONTROL_REG,
  input wire logic [1:0] CORE_STATUS,
  input wire logic SLEEPING,
  input wire logic PC_LOAD,
  input wire logic [PC_W-1:0] PC_LOAD_ADDR,
  input wire logic RESUME_NEXT,
  input wire logic PUSH_RETURN
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  wire np = !(BROWNOUT_DET || EXTERNAL_RESET_PIN);
  wire q0 = np && !(WATCHDOG_TIMER_EXPIRE || STACK_OVERFLOW || STACK_UNDERFLOW);
  wire q = q0 && !RESET_INSTR;
  bor_restart_a: assert property (
    $rose(BROWNOUT_DET) |-> ##[2:6] (PC_LOAD && POWER_CONTROL_REG[7:6] == 2'h0
    && !POWER_CONTROL_REG[0] && CORE_STATUS == 2'h3)) else $error("brownout restart");
  pin_restart_a: assert property (
    $rose(EXTERNAL_RESET_PIN) |-> ##[2:6] (PC_LOAD && !POWER_CONTROL_REG[3] && !SLEEPING))
    else $error("pin restart");
  wdog_reset_a: assert property (
    WATCHDOG_TIMER_EXPIRE && np && !SLEEPING |=> PC_LOAD && PC_LOAD_ADDR == 0
    && !POWER_CONTROL_REG[4] && !CORE_STATUS[1]) else $error("watchdog reset");
  wdog_wake_a: assert property (
    WATCHDOG_TIMER_EXPIRE && np && SLEEPING |=> RESUME_NEXT && !PC_LOAD
    && CORE_STATUS == 2'h0 && $stable(POWER_CONTROL_REG)) else $error("watchdog wake");
  irq_wake_a: assert property (
    IRQ_WAKE && SLEEPING && q |=> RESUME_NEXT && !PC_LOAD && !SLEEPING
    && CORE_STATUS == 2'h2 && $stable(POWER_CONTROL_REG)) else $error("irq wake");
  isr_call_a: assert property (
    PUSH_RETURN |-> PC_LOAD && PC_LOAD_ADDR == 'h4 && $past(INSTR_DONE))
    else $error("isr call");
  instr_restart_a: assert property (
    RESET_INSTR && q0 |=> PC_LOAD && PC_LOAD_ADDR == 0 && !POWER_CONTROL_REG[2]
    && POWER_CONTROL_REG[7:3] == $past(POWER_CONTROL_REG[7:3])) else $error("reset instr");
  ovf_flag_a: assert property (
    STACK_OVERFLOW && np && !WATCHDOG_TIMER_EXPIRE ##1 PC_LOAD
    |-> POWER_CONTROL_REG[7] && PC_LOAD_ADDR == 0) else $error("overflow flag");
  unf_flag_a: assert property (
    STACK_UNDERFLOW && np && !WATCHDOG_TIMER_EXPIRE && !STACK_OVERFLOW ##1 PC_LOAD
    |-> POWER_CONTROL_REG[6] && PC_LOAD_ADDR == 0) else $error("underflow flag");
  cover property (PUSH_RETURN);
  cover property (RESUME_NEXT && CORE_STATUS == 2'h0);
  cover property ($rose(BROWNOUT_DET));
endmodule
`default_nettype wire

/* File: sim/rcr_top_test.sv */
// Purpose: Self-checking bench of the cause recorder.
// Assumes: No wait states; registers 00 power, 04 core, 08 events, 0c mask, 10 control.
// Notes: The driver keeps the expected flag images and queues each read result.
`timescale 1ns/10ps
`default_nettype none
`define CHK(x, y) begin cmp_count++; if ((x) !== (y)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, x, y); end end
module rcr_top_test;
  logic clk = 0, rstn = 0, sel = 0, wr = 0, glob_en = 0, rd_ph = 0, sm = 0, en = 1;
  logic [7:0] addr = 0, pm = 8'h1f, es = 0;
  logic [1:0] trans = 0, pin = 0, cm = 2'h3;
  logic [5:0] ev = 0;
  logic [3:0] dly = 0;
  logic [31:0] wdata = 0, e, r;
  logic [31:0] exp_q[$];
  int miscompares = 0, cmp_count = 0, seed = 32'hfdb800b1;
  int seq[16] = '{6, 1, 6, 1, 0, 1, 2, 2, 0, 3, 4, 5, 8, 4, 5, 7};
  int dl[2] = '{0, 9};
  wire hrdy, done, rsm, irq, push, resp;
  wire [31:0] rdata;
  wire [14:0] pca;
  rcr_top rcr_top_i (.REF_CLK(clk), .RSTN(rstn), .HSEL(sel), .HADDR(addr), .HTRANS(trans),
    .HWRITE(wr), .HSIZE(3'h2), .HWDATA(wdata), .HREADY(hrdy), .HRDATA(rdata),
    .HREADYOUT(hrdy), .HRESP(resp), .EXTERNAL_RESET_PIN(pin[0]), .BROWNOUT_DET(pin[1]),
    .WATCHDOG_TIMER_EXPIRE(ev[0]), .SLEEP_ENTER(ev[1]), .IRQ_WAKE(ev[2]),
    .RESET_INSTR(ev[3]), .STACK_OVERFLOW(ev[4]), .STACK_UNDERFLOW(ev[5]),
    .GLOBAL_IRQ_EN(glob_en), .INSTR_DONE(done), .POWER_CONTROL_REG(), .CORE_STATUS(),
    .SLEEPING(), .PC_LOAD(), .PC_LOAD_ADDR(pca), .RESUME_NEXT(rsm), .PUSH_RETURN(push),
    .IRQ(irq));
  rcr_core_model rcr_core_model_i (.clk(clk), .rstn(rstn), .resume(rsm), .dly(dly),
    .done(done));
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (rd_ph)
    begin
      e = exp_q.pop_front();
      `CHK(rdata, e)
      `CHK(resp, 1'b0)
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wt();
    int n;
    n = 0;
    @(posedge clk);
    while (hrdy !== 1'b1 && n < 64)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 64)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // A read passes its expected word in d, queued after the address-phase edge, one edge before the checker pops it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    sel <= 1'b1;
    trans <= 2'h2;
    wr <= w;
    addr <= a;
    wt();
    trans <= 2'h0;
    wdata <= d;
    rd_ph <= !w;
    if (!w)
    begin
      exp_q.push_back(d);
    end
    wt();
    rd_ph <= 1'b0;
  endtask
  task automatic act(input int k);
    if (k < 6)
    begin
      ev[k] <= 1'b1;
      @(posedge clk);
      ev <= 6'h0;
    end
    else if (k < 8)
    begin
      pin[k-6] <= 1'b1;
      repeat (8) @(posedge clk);
      pin <= 2'h0;
    end
    else
    begin
      bus(1, 8'h10, 32'h0);
      en = 0;
    end
    case (k)
      0:
      begin
        es |= sm ? 8'h08 : 8'h04;
        pm[4] &= sm;
        cm = {1'b0, cm[0] & !sm};
      end
      1:
      begin
        cm = 2'h2;
        sm = 1;
      end
      2, 6:
      begin
        es |= k == 6 ? 8'h02 : {3'h0, sm, 4'h0};
        pm[3] &= k != 6;
        cm = sm ? 2'h2 : cm;
      end
      3:
      begin
        es |= 8'h20;
        pm[2] = 0;
      end
      4, 5:
      begin
        es[k+2] |= en;
        pm[11-k] |= en;
      end
      7:
      begin
        es |= 8'h01;
        pm = {2'h0, pm[5:4], 2'h3, pm[1], 1'b0};
        cm = 2'h3;
      end
    endcase
    if (k != 1)
    begin
      sm = 0;
    end
  endtask
  initial
  begin
    int n;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(0, 8'h00, 32'h1d);
    bus(0, 8'h04, 32'h3);
    bus(0, 8'h10, 32'h1);
    bus(0, 8'h14, 32'h0);
    r = $random(seed);
    bus(1, 8'h00, r);
    bus(0, 8'h00, {24'h0, r[7:0] & 8'hdf});
    bus(1, 8'h00, 32'h1f);
    bus(1, 8'h04, r);
    foreach (seq[i])
    begin
      act(seq[i]);
      repeat (4) @(posedge clk);
      bus(0, 8'h00, {24'h0, pm});
      bus(0, 8'h04, {30'h0, cm});
      bus(0, 8'h08, {24'h0, es});
    end
    glob_en <= 1'b1;
    foreach (dl[i])
    begin
      dly <= dl[i][3:0];
      act(1);
      @(posedge clk);
      act(2);
      n = 0;
      while (push !== 1'b1 && n < 40)
      begin
        @(posedge clk);
        n++;
      end
      if (n == 40)
      begin
        miscompares++;
        tally_and_finish();
      end
      `CHK(push, 1'b1)
      `CHK(pca, 15'h0004)
    end
    r = $random(seed);
    bus(1, 8'h0c, r);
    bus(0, 8'h0c, {24'h0, r[7:0]});
    `CHK(irq, |(es & r[7:0]))
    bus(1, 8'h0c, 32'hff);
    bus(0, 8'h0c, 32'hff);
    `CHK(irq, 1'b1)
    bus(1, 8'h08, 32'hff);
    bus(0, 8'h08, 32'h0);
    `CHK(irq, 1'b0)
    // Second power-on in mid-run: flags, mask and status must return to reset values
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(0, 8'h00, 32'h1d);
    bus(0, 8'h04, 32'h3);
    bus(0, 8'h0c, 32'h0);
    bus(0, 8'h08, 32'h0);
    `CHK(irq, 1'b0)
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule
bind rcr_top rcr_top_asserts #(.PC_W(PC_W)) rcr_top_asserts_i (.*);
`default_nettype wire
